/* rtl/rdo_ctrl.sv */
// Receiver detection, COM sequence generation, beacon selection and power-state decode for one lane.
// Assumes lane requests come from another domain and are resynchronised here; APB slave for setup.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - SATA format: bit0 COM done, bit1 COMWAKE seen, bit2 COMRESET/COMINIT seen.
// - PCIe format: status carries no out-of-band information.
// - Detect request starts detection; ends with done flag and valid status.
// - Power codes: 00 normal, 01 quick recovery, 10 detect capable, 11 lowest.
// - Detection end pulses done flag one cycle with the result code; in SATA format the status keeps the COM bits instead.
// - PCIe detection result: 000 no receiver, 011 receiver present.
// - SATA only: COM start request sends the selected COM sequence.
// - COM select 0 sends COMRESET/COMINIT, 1 sends COMWAKE.
// - In lowest power, idle control picks electrical idle or beacon.
// - A 4-bit burst count sets bursts per COM sequence.
// - Transmit rate divider accepts only 1, 2 or 4.
// - COM timing scales with the rate divider.
// - COM completion drives status bit0 high for one cycle.
// - In lowest power, dropping idle control starts beacon transmission.
module rdo_ctrl
  import rdo_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_detect_request,
  input  wire logic        com_sequence_start,
  input  wire logic        com_sequence_select,
  input  wire logic        tx_idle_control,
  input  wire logic [1:0]  tx_power_state,
  input  wire logic [1:0]  rx_power_state,
  input  wire logic        rx_present_sense,
  input  wire logic        rx_comwake_seen,
  input  wire logic        rx_cominit_seen,
  output logic      [2:0]  rx_status_code,
  output logic             phy_done_flag,
  output logic      [1:0]  tx_line_mode,
  output logic      [3:0]  tx_power_mode,
  output logic      [3:0]  rx_power_mode
);

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic            det_q;
    logic            wake_q;
    logic            init_q;
    rdo_state_t      st;
    logic [11:0]     timer;
    logic [3:0]      bursts;
    logic            com_sel;
    logic            det_present;
    logic [2:0]      code;
    logic            done;
    rdo_line_t       line;
    logic [3:0]      tx_pmode;
    logic [3:0]      rx_pmode;
    logic            fmt;
    logic            pll_opt;
    logic [3:0]      burst_total;
    logic [2:0]      div;
    logic [11:0]     det_ivl;
    logic            ack;
    logic [31:0]     rdata;
  } rdo_regs_t;

  rdo_regs_t r_ff;
  rdo_regs_t nxt_r;

  function automatic logic [3:0] rdo_pdecode(input logic [1:0] ps);
    rdo_pdecode = 4'h1 << ps;
  endfunction

  function automatic logic [11:0] rdo_scale(input logic [11:0] base, input logic [2:0] div);
    rdo_scale = 12'(base * div);
  endfunction

  logic [SY_W-1:0] pins;
  logic            det_req;
  logic            com_start;
  logic            idle_ctl;
  logic [1:0]      txps;
  logic            wake_rise;
  logic            init_rise;
  logic            acc;
  logic            mapped;
  logic [2:0]      wdiv;

  assign pins      = {rx_cominit_seen, rx_comwake_seen, rx_present_sense, rx_power_state,
                      tx_power_state, tx_idle_control, com_sequence_select, com_sequence_start,
                      rx_detect_request};
  assign det_req   = r_ff.sync2[SY_DET];
  assign com_start = r_ff.sync2[SY_START];
  assign idle_ctl  = r_ff.sync2[SY_IDLE];
  assign txps      = r_ff.sync2[SY_TXPS +: 2];
  assign wake_rise = r_ff.sync2[SY_WAKE] & ~r_ff.wake_q;
  assign init_rise = r_ff.sync2[SY_INIT] & ~r_ff.init_q;
  assign acc       = psel & penable;
  assign mapped    = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_DETCFG);
  assign wdiv      = pwdata[CTRL_DIV_LSB +: 3];

  // Second access cycle answers so that read data comes from a flop
  assign pready  = acc & r_ff.ack;
  assign pslverr = pready & ~mapped;

  always_comb
  begin
    nxt_r       = r_ff;
    nxt_r.sync1 = pins;
    nxt_r.sync2 = r_ff.sync1;
    nxt_r.det_q  = det_req;
    nxt_r.wake_q = r_ff.sync2[SY_WAKE];
    nxt_r.init_q = r_ff.sync2[SY_INIT];
    nxt_r.done  = 1'b0;
    nxt_r.tx_pmode = rdo_pdecode(txps);
    nxt_r.rx_pmode = rdo_pdecode(r_ff.sync2[SY_RXPS +: 2]);
    if (r_ff.fmt == FMT_SATA)
      nxt_r.code = {init_rise, wake_rise, 1'b0};
    else
      nxt_r.code = CODE_NONE;

    unique case (r_ff.st)
      RDO_IDLE:
      begin
        if (det_req & ~r_ff.det_q)
        begin
          nxt_r.st    = RDO_DET;
          nxt_r.timer = r_ff.det_ivl;
        end
        else if (com_start & (r_ff.fmt == FMT_SATA))
        begin
          nxt_r.st      = RDO_BURST;
          nxt_r.com_sel = r_ff.sync2[SY_SEL];
          nxt_r.bursts  = 4'h0;
          nxt_r.timer   = rdo_scale(BURST_CYC, r_ff.div);
        end
      end
      RDO_DET:
      begin
        if (r_ff.timer == 12'h000)
        begin
          nxt_r.st          = RDO_IDLE;
          nxt_r.done        = 1'b1;
          nxt_r.det_present = r_ff.sync2[SY_PRES];
          if (r_ff.fmt == FMT_PCIE)
            nxt_r.code = r_ff.sync2[SY_PRES] ? CODE_PRESENT : CODE_NONE;
        end
        else
          nxt_r.timer = r_ff.timer - 12'h001;
      end
      RDO_BURST:
      begin
        if (r_ff.timer == 12'h000)
        begin
          nxt_r.st    = RDO_GAP;
          // Gap length is what tells COMWAKE from COMRESET/COMINIT
          nxt_r.timer = rdo_scale(r_ff.com_sel ? GAP_WAKE_CYC : GAP_INIT_CYC, r_ff.div);
        end
        else
          nxt_r.timer = r_ff.timer - 12'h001;
      end
      RDO_GAP:
      begin
        if (r_ff.timer != 12'h000)
          nxt_r.timer = r_ff.timer - 12'h001;
        else if (r_ff.bursts + 4'h1 >= r_ff.burst_total)
        begin
          nxt_r.st   = RDO_IDLE;
          nxt_r.code = {nxt_r.code[2:1], 1'b1};
        end
        else
        begin
          nxt_r.st     = RDO_BURST;
          nxt_r.bursts = r_ff.bursts + 4'h1;
          nxt_r.timer  = rdo_scale(BURST_CYC, r_ff.div);
        end
      end
    endcase

    if (nxt_r.st == RDO_BURST)
      nxt_r.line = LINE_BURST;
    else if (nxt_r.st == RDO_GAP)
      nxt_r.line = LINE_IDLE;
    else if (txps == PS_LOWEST)
      nxt_r.line = idle_ctl ? LINE_IDLE : LINE_BEACON;
    else
      nxt_r.line = idle_ctl ? LINE_IDLE : LINE_DATA;

    nxt_r.ack = acc & ~r_ff.ack;
    if (acc & ~r_ff.ack)
    begin
      unique case (paddr)
        ADDR_CTRL:
          nxt_r.rdata = {21'h0, r_ff.div, r_ff.burst_total, 2'h0, r_ff.pll_opt, r_ff.fmt};
        ADDR_STATUS:
          nxt_r.rdata = {16'h0, r_ff.rx_pmode, r_ff.tx_pmode, r_ff.det_present, r_ff.code,
                         r_ff.line, r_ff.st};
        ADDR_DETCFG:
          nxt_r.rdata = {20'h0, r_ff.det_ivl};
        default:
          nxt_r.rdata = 32'h0;
      endcase
    end
    if (pready & pwrite)
    begin
      if (paddr == ADDR_CTRL)
      begin
        nxt_r.fmt         = pwdata[CTRL_FMT_BIT];
        nxt_r.pll_opt     = pwdata[CTRL_PLL_BIT];
        nxt_r.burst_total = pwdata[CTRL_BURST_LSB +: 4];
        // Other divider values would give COM timing outside spec; keep old one
        if (wdiv == 3'h1 || wdiv == 3'h2 || wdiv == 3'h4)
          nxt_r.div = wdiv;
      end
      if (paddr == ADDR_DETCFG)
        nxt_r.det_ivl = pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_ff             <= '0;
      r_ff.st          <= RDO_IDLE;
      r_ff.line        <= LINE_DATA;
      r_ff.tx_pmode    <= 4'h1;
      r_ff.rx_pmode    <= 4'h1;
      r_ff.fmt         <= FMT_RST;
      r_ff.burst_total <= BURST_RST;
      r_ff.div         <= DIV_RST;
      r_ff.det_ivl     <= DETIVL_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign prdata         = r_ff.rdata;
  assign rx_status_code = r_ff.code;
  assign phy_done_flag  = r_ff.done;
  assign tx_line_mode   = r_ff.line;
  assign tx_power_mode  = r_ff.tx_pmode;
  assign rx_power_mode  = r_ff.rx_pmode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DONE_ONE_CYCLE: assert property (phy_done_flag |=> !phy_done_flag)
    else $error("done flag longer than one cycle");
  AST_PCIE_RESULT: assert property ((r_ff.st == RDO_DET) && (r_ff.timer == 12'h000) && (r_ff.fmt == FMT_PCIE)
    |=> phy_done_flag && rx_status_code == (r_ff.det_present ? CODE_PRESENT : CODE_NONE))
    else $error("wrong detection result code");
  AST_PCIE_QUIET: assert property ((r_ff.fmt == FMT_PCIE) && !phy_done_flag |-> rx_status_code == CODE_NONE)
    else $error("status not quiet in PCIe format");
  AST_COM_DONE_PULSE: assert property ((r_ff.fmt == FMT_SATA) && rx_status_code[0] |=> !rx_status_code[0])
    else $error("COM done bit longer than one cycle");
  AST_WAKE_BIT: assert property ((r_ff.fmt == FMT_SATA) && wake_rise |=> rx_status_code[1])
    else $error("COMWAKE not reported");
  AST_DET_START: assert property ((r_ff.st == RDO_IDLE) && det_req && !r_ff.det_q |=> r_ff.st == RDO_DET)
    else $error("detection not started");
  AST_COM_START: assert property ((r_ff.st == RDO_IDLE) && com_start && (r_ff.fmt == FMT_SATA)
    && !(det_req && !r_ff.det_q) |=> r_ff.st == RDO_BURST ##1 tx_line_mode == LINE_BURST)
    else $error("COM sequence not started");
  AST_GAP_LEN: assert property ((r_ff.st == RDO_BURST) && (r_ff.timer == 12'h000)
    |=> r_ff.timer == 12'((r_ff.com_sel ? GAP_WAKE_CYC : GAP_INIT_CYC) * r_ff.div))
    else $error("gap length wrong");
  AST_BURST_LEN: assert property ($rose(r_ff.st == RDO_BURST) |-> r_ff.timer == 12'(BURST_CYC * r_ff.div))
    else $error("burst length not scaled");
  AST_BURST_COUNT: assert property (r_ff.st == RDO_BURST |-> r_ff.bursts < r_ff.burst_total
    || r_ff.burst_total == 4'h0)
    else $error("too many bursts");
  AST_DIV_LEGAL: assert property (r_ff.div == 3'h1 || r_ff.div == 3'h2 || r_ff.div == 3'h4)
    else $error("illegal divider");
  AST_BEACON: assert property ((r_ff.st == RDO_IDLE) && (txps == PS_LOWEST) && !idle_ctl
    && !(det_req && !r_ff.det_q) && !(com_start && r_ff.fmt == FMT_SATA) |=> tx_line_mode == LINE_BEACON)
    else $error("beacon not driven");
  AST_PDECODE: assert property (1'b1 |=> tx_power_mode == 4'(4'h1 << $past(txps)))
    else $error("power decode wrong");

  COV_DETECT: cover property (phy_done_flag && rx_status_code == CODE_PRESENT);
  COV_COM: cover property ((r_ff.fmt == FMT_SATA) && rx_status_code[0]);
  COV_BEACON: cover property (tx_line_mode == LINE_BEACON);

endmodule

`default_nettype wire

/* rtl/rdo_pkg.sv */
// Constants, register map and types of the receiver-detect / out-of-band / power control block.
// Assumes a single 125 MHz APB clock on which every lane-side request is sampled.
package rdo_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  // APB map
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_DETCFG    = 8'h08;
  // Control register fields
  localparam int unsigned CTRL_FMT_BIT   = 0;
  localparam int unsigned CTRL_PLL_BIT   = 1;
  localparam int unsigned CTRL_BURST_LSB = 4;
  localparam int unsigned CTRL_DIV_LSB   = 8;
  // Reset values
  localparam logic        FMT_RST        = 1'b0;
  localparam logic [3:0]  BURST_RST      = 4'h6;
  localparam logic [2:0]  DIV_RST        = 3'h1;
  localparam logic [11:0] DETIVL_RST     = 12'h040;
  // Status formats and codes
  localparam logic        FMT_PCIE       = 1'b0;
  localparam logic        FMT_SATA       = 1'b1;
  localparam logic [2:0]  CODE_NONE      = 3'h0;
  localparam logic [2:0]  CODE_PRESENT   = 3'h3;
  // Power state codes
  localparam logic [1:0]  PS_NORMAL      = 2'h0;
  localparam logic [1:0]  PS_QUICK       = 2'h1;
  localparam logic [1:0]  PS_DETECT      = 2'h2;
  localparam logic [1:0]  PS_LOWEST      = 2'h3;
  // COM timing at divider 1, in ns, and the cycle counts derived from it
  localparam int unsigned BURST_NS       = 104;
  localparam int unsigned GAP_INIT_NS    = 312;
  localparam int unsigned GAP_WAKE_NS    = 104;
  localparam logic [11:0] BURST_CYC      = 12'((BURST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] GAP_INIT_CYC   = 12'((GAP_INIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] GAP_WAKE_CYC   = 12'((GAP_WAKE_NS * CLK_MHZ + 999) / 1000);
  // Synchroniser vector layout
  localparam int unsigned SY_DET         = 0;
  localparam int unsigned SY_START       = 1;
  localparam int unsigned SY_SEL         = 2;
  localparam int unsigned SY_IDLE        = 3;
  localparam int unsigned SY_TXPS        = 4;
  localparam int unsigned SY_RXPS        = 6;
  localparam int unsigned SY_PRES        = 8;
  localparam int unsigned SY_WAKE        = 9;
  localparam int unsigned SY_INIT        = 10;
  localparam int unsigned SY_W           = 11;

  typedef enum logic [1:0] {
    RDO_IDLE  = 2'b00,
    RDO_DET   = 2'b01,
    RDO_BURST = 2'b11,
    RDO_GAP   = 2'b10
  } rdo_state_t;

  typedef enum logic [1:0] {
    LINE_DATA   = 2'h0,
    LINE_IDLE   = 2'h1,
    LINE_BEACON = 2'h2,
    LINE_BURST  = 2'h3
  } rdo_line_t;
endpackage

/* bench/rdo_far_end.sv */
// Far-end model: remote receiver presence and a serial ATA device answering COM sequences.
// Assumes it watches the lane's transmit line mode on the bench clock.
`timescale 1ns/1ns
`default_nettype none
module rdo_far_end
  import rdo_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       present_en,
  input  wire logic [1:0] tx_line_mode,
  output logic            rx_present_sense,
  output logic            rx_comwake_seen,
  output logic            rx_cominit_seen
);
  int   blen, g, r, hold;
  logic in_b, was_b, kind_init;
  assign rx_present_sense = present_en;
  // Gap length against burst length tells the COM type whatever the divider is
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {blen, g, r, hold, was_b, kind_init} = '0;
      rx_comwake_seen <= 1'b0;
      rx_cominit_seen <= 1'b0;
    end
    else
    begin
      in_b = (tx_line_mode == LINE_BURST);
      if (in_b != was_b)
      begin
        if (was_b)
          blen = r;
        else if (blen > 0)
        begin
          g = r;
          kind_init = r > 2 * blen;
        end
        r = 0;
      end
      r++;
      was_b = in_b;
      hold = (hold > 0) ? hold - 1 : 0;
      // Answer only once the line has stayed quiet well past a gap
      if (!in_b && g > 0 && r == 2 * g + 2)
      begin
        hold = 4;
        g = 0;
        blen = 0;
      end
      rx_comwake_seen <= hold > 0 && !kind_init;
      rx_cominit_seen <= hold > 0 && kind_init;
    end
endmodule
`default_nettype wire

/* bench/rx_detect_oob_power_control_tb.sv */
// Self-checking bench: APB setup, power decode, receiver detection, COM sequences, beacon.
// Assumes rdo_pkg, the control block and the far-end model rdo_far_end.
`timescale 1ns/1ns
`default_nettype none
module rx_detect_oob_power_control_tb
  import rdo_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_detect_request, com_sequence_start, com_sequence_select, tx_idle_control;
  logic        rx_present_sense, rx_comwake_seen, rx_cominit_seen, phy_done_flag, present_en, bad;
  logic [1:0]  tx_power_state, rx_power_state, tx_line_mode;
  logic [2:0]  rx_status_code;
  logic [3:0]  tx_power_mode, rx_power_mode;
  int          bad_count = 0, comparisons = 0, cycles = 0, seed;

  rdo_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_detect_request, .com_sequence_start, .com_sequence_select, .tx_idle_control, .tx_power_state,
    .rx_power_state, .rx_present_sense, .rx_comwake_seen, .rx_cominit_seen, .rx_status_code,
    .phy_done_flag, .tx_line_mode, .tx_power_mode, .rx_power_mode);
  rdo_far_end far_u (.pclk, .presetn, .present_en, .tx_line_mode, .rx_present_sense, .rx_comwake_seen,
    .rx_cominit_seen);

  always #4 pclk = ~pclk;

  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer taken at the rising edge where pready is sampled high, released just after it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic line_case(input logic [1:0] ps, input logic idle, input logic [1:0] exp);
    @(posedge pclk);
    tx_power_state  <= ps;
    rx_power_state  <= ps;
    tx_idle_control <= idle;
    repeat (5) @(negedge pclk);
    chk(tx_line_mode, exp);
  endtask

  task automatic detect(input logic pres, input int ivl);
    int n;
    apb(1'b1, ADDR_DETCFG, 32'(ivl));
    present_en <= pres;
    @(posedge pclk);
    rx_detect_request <= 1'b1;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (phy_done_flag !== 1'b1 && n < ivl + 20);
    chk(32'(n > ivl && n < ivl + 8), 32'h1);
    chk(rx_status_code, pres ? CODE_PRESENT : CODE_NONE);
    @(negedge pclk);
    chk({phy_done_flag, rx_status_code}, 32'h0);
    @(posedge pclk);
    rx_detect_request <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic com_run(input logic sel, input logic [2:0] d, input logic [3:0] b);
    int nb, bl, gl, gap, n;
    logic [1:0] prev;
    apb(1'b1, ADDR_CTRL, {21'h0, d, b, 4'h1});
    @(posedge pclk);
    com_sequence_select <= sel;
    com_sequence_start  <= 1'b1;
    @(posedge pclk);
    com_sequence_start <= 1'b0;
    {nb, bl, gl, prev} = '0;
    gap = sel ? int'(GAP_WAKE_CYC) * d + 1 : int'(GAP_INIT_CYC) * d + 1;
    for (n = 0; n < 4000; n++)
    begin
      @(negedge pclk);
      if (rx_status_code[0] === 1'b1)
        break;
      if (tx_line_mode === LINE_BURST && prev !== LINE_BURST)
        nb++;
      bl += int'(tx_line_mode === LINE_BURST);
      gl += int'(tx_line_mode === LINE_IDLE && nb > 0);
      prev = tx_line_mode;
    end
    chk(nb, (b == 4'h0) ? 1 : b);
    chk(bl, nb * (int'(BURST_CYC) * d + 1));
    chk(32'(gl >= (nb - 1) * gap && gl <= nb * gap + 2), 32'h1);
    @(negedge pclk);
    chk(rx_status_code[0], 1'b0);
    if (b > 4'h1)
    begin
      for (n = 0; n < 1000 && rx_status_code[2:1] === 2'b00; n++)
        @(negedge pclk);
      chk(rx_status_code[2:1], sel ? 2'b01 : 2'b10);
    end
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, present_en, bad} = '0;
    {rx_detect_request, com_sequence_start, com_sequence_select} = '0;
    tx_idle_control = 1'b1;
    tx_power_state  = PS_NORMAL;
    rx_power_state  = PS_NORMAL;
    seed = 32'hc71c;
    repeat (16) @(posedge pclk);
    chk({tx_power_mode, rx_power_mode, phy_done_flag, rx_status_code}, {8'h11, 4'h0});
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, {21'h0, DIV_RST, BURST_RST, 4'h0});
    apb(1'b0, ADDR_DETCFG, 32'h0);
    chk(rd, 32'(DETIVL_RST));
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // Divider 3 is refused while the burst field still lands
    apb(1'b1, ADDR_CTRL, 32'h0000_0340);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, {21'h0, DIV_RST, 4'h4, 4'h0});
    for (int ps = 0; ps < 4; ps++)
    begin
      @(posedge pclk);
      tx_power_state <= 2'(ps);
      rx_power_state <= 2'($random(seed));
      repeat (5) @(negedge pclk);
      chk(tx_power_mode, 4'b1 << ps);
      chk(rx_power_mode, 4'b1 << rx_power_state);
    end
    line_case(PS_LOWEST, 1'b0, LINE_BEACON);
    line_case(PS_LOWEST, 1'b1, LINE_IDLE);
    line_case(PS_NORMAL, 1'b0, LINE_DATA);
    line_case(PS_DETECT, 1'b1, LINE_IDLE);
    detect(1'b1, 8 + ($unsigned($random(seed)) % 8));
    detect(1'b0, 8 + ($unsigned($random(seed)) % 8));
    line_case(PS_NORMAL, 1'b1, LINE_IDLE);
    // Format is still the other one here, so a start must be ignored
    @(posedge pclk);
    com_sequence_start <= 1'b1;
    @(posedge pclk);
    com_sequence_start <= 1'b0;
    repeat (100)
    begin
      @(negedge pclk);
      bad = bad | (tx_line_mode === LINE_BURST) | (rx_status_code !== CODE_NONE);
    end
    chk(bad, 1'b0);
    for (int i = 0; i < 3; i++)
      com_run(i[0], 3'(1 << i), 4'(2 + $unsigned($random(seed)) % 4));
    com_run(1'b1, 3'h1, 4'h0);
    stop_test();
  end
endmodule
`default_nettype wire
